//--- shared/urc_consts.vh
// Purpose: Constants for the unstructured reassembly control register bank
// Assumes: Classic Wishbone slave with 32-bit data, one register per word
// Notes:   Printed offsets are not all multiples of four, so they are indexes
`ifndef URC_CONSTS_VH
`define URC_CONSTS_VH

// Register indexes (byte address is four times the index)
`define URC_IDX_FILL_CTRL     16'h2000
`define URC_IDX_SERVICE_EN    16'h2002
`define URC_IDX_EVENT_STATUS  16'h2004
`define URC_IDX_IRQ_STATUS    16'h2010
`define URC_IDX_IRQ_MASK      16'h2012
`define URC_IDX_TIMEOUT_BASE  16'h3200
`define URC_IDX_W             16

// Reset values
`define URC_FILL_RESET        16'h00FF
`define URC_SERV_RESET        16'h0000
`define URC_PORT_ILLEGAL      5'h1F

// Fill control fields
`define URC_FILL_OCTET_HI     7
`define URC_INSERT_LOST_BIT   8
`define URC_LATE_CHECK_BIT    9
`define URC_FILL_USED_W       10

// Service enable fields
`define URC_SERV_USED_W       4

// Event status fields
`define URC_EVT_FLAG_BIT      15

// Interrupt status bits
`define URC_IRQ_W             2
`define URC_IRQ_EVENT_BIT     0
`define URC_IRQ_DONE_BIT      1

// Dummy cell payload and cell counts
`define URC_CELL_OCTETS       6'd47
`define URC_LOST_CAP_ON       3'd7
`define URC_LOST_CAP_OFF      3'd2

`endif

//--- src/urc_timeout_mem.v
// Purpose: Per-port late-cell timeout store, one word per port
// Assumes: Single clock, one write port and one registered read port
// Notes:   Read data appear one cycle after the address is presented
`timescale 1ns/100ps

module urc_timeout_mem #(
   parameter PORTS = 8,
   parameter AW    = 3,
   parameter DW    = 16
) (
   // Clock
   input  wire          i_clock,
   // Write side
   input  wire          i_wr_en,
   input  wire [AW-1:0] i_wr_addr,
   input  wire [DW-1:0] i_wr_data,
   // Read side
   input  wire [AW-1:0] i_rd_addr,
   output reg  [DW-1:0] o_rd_data
);

   reg [DW-1:0] mem_reg [0:PORTS-1];

   // Synchronous write and registered read; no reset so it maps to RAM
   always @(posedge i_clock) begin
      if (i_wr_en) begin
         mem_reg[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem_reg[i_rd_addr];
   end

endmodule // urc_timeout_mem

//--- src/urc_reassembly_ctrl.v
// Purpose: Unstructured reassembly control bank with dummy cell writer
// Assumes: Classic Wishbone slave; per-port events arrive as pulses from
//          the reassembly engine on this clock
// Notes:   One dummy-cell request is served at a time; others wait
//
// Summary of operation
// - Dummy cell writes fill octet 47 times
// - Fill octet resets to all ones
// - Lost-count mode inserts lost cells, capped seven
// - Otherwise at most two cells per loss
// - Late check inserts one cell on timeout
// - Timeout period read from per-port register
// - Enable bit0 gates reassembled rollover event
// - Enable bit1 gates header error rollover
// - Enable bit2 gates sequence error rollover
// - Enable bit3 gates lost cell rollover
// - Writing zero clears flag, port to 1Fh
// - Record port of latest unmasked rollover
`timescale 1ns/100ps
`include "urc_consts.vh"

module urc_reassembly_ctrl #(
   parameter PORTS = 8,
   parameter PW    = 3,
   parameter TW    = 16
) (
   // Clock and reset
   input  wire             i_clock,
   input  wire             i_resetn,
   // Wishbone slave
   input  wire             i_wb_cyc,
   input  wire             i_wb_stb,
   input  wire             i_wb_we,
   input  wire [17:0]      i_wb_adr,
   input  wire [3:0]       i_wb_sel,
   input  wire [31:0]      i_wb_dat,
   output reg  [31:0]      o_wb_dat,
   output reg              o_wb_ack,
   // Per-port counter rollover pulses from the control structures
   input  wire [PORTS-1:0] i_reass_roll,
   input  wire [PORTS-1:0] i_hdr_err_roll,
   input  wire [PORTS-1:0] i_seq_err_roll,
   input  wire [PORTS-1:0] i_lost_roll,
   // Multi-cell loss report
   input  wire             i_loss_valid,
   input  wire [PW-1:0]    i_loss_port,
   input  wire [2:0]       i_loss_count,
   output wire             o_loss_ready,
   // Per-port sync state and a late-cell restart pulse (cell arrived)
   input  wire [PORTS-1:0] i_port_in_sync,
   input  wire [PORTS-1:0] i_cell_arrived,
   // Circular buffer write port
   output reg              o_buf_wr,
   output reg  [PW-1:0]    o_buf_port,
   output reg  [7:0]       o_buf_data,
   input  wire             i_buf_ready,
   // Interrupt
   output wire             o_irq
);

   // State machine codes, one-hot
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_WRITE = 3'b010;
   localparam [2:0] ST_NEXT  = 3'b100;

   // Reset values; only the implemented low bits are kept in the registers
   localparam [15:0] FILL_RST = `URC_FILL_RESET;
   localparam [15:0] SERV_RST = `URC_SERV_RESET;

   // Registers
   reg [`URC_FILL_USED_W-1:0] fill_ctrl_reg;
   reg [`URC_SERV_USED_W-1:0] serv_en_reg;
   reg                        evt_flag_reg;
   reg [4:0]                  evt_port_reg;
   reg [`URC_IRQ_W-1:0]       irq_stat_reg;
   reg [`URC_IRQ_W-1:0]       irq_mask_reg;
   reg [2:0]                  state_reg;
   reg [5:0]                  octet_cnt_reg;
   reg [2:0]                  cells_left_reg;
   reg [PW-1:0]               cur_port_reg;
   reg [PW-1:0]               scan_port_reg;
   wire [PORTS-1:0]           late_pend;     // Queued late-cell insertions

   // Bus decode
   wire               bus_req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   wire [15:0]        reg_idx    = i_wb_adr[17:2];
   wire               bus_wr     = bus_req & i_wb_we;
   wire               bus_rd     = bus_req & ~i_wb_we;
   wire               lo_lane    = i_wb_sel[0];
   wire               hi_lane    = i_wb_sel[1];
   wire               sel_fill   = (reg_idx == `URC_IDX_FILL_CTRL);
   wire               sel_serv   = (reg_idx == `URC_IDX_SERVICE_EN);
   wire               sel_evt    = (reg_idx == `URC_IDX_EVENT_STATUS);
   wire               sel_istat  = (reg_idx == `URC_IDX_IRQ_STATUS);
   wire               sel_imask  = (reg_idx == `URC_IDX_IRQ_MASK);
   wire               sel_tmo    = (reg_idx[15:PW+1] ==
                                    `URC_IDX_TIMEOUT_BASE >> (PW+1)) &
                                   ~reg_idx[0];
   wire [PW-1:0]      tmo_port   = reg_idx[PW:1];
   wire [TW-1:0]      tmo_rdata;

   // Lowest-numbered port with an unmasked rollover this cycle
   function [PW:0] first_port;
      input [PORTS-1:0] vec;
      integer k;
      begin
         first_port = {(PW+1){1'b0}};
         for (k = PORTS-1; k >= 0; k = k - 1) begin
            if (vec[k]) begin
               first_port = {1'b1, k[PW-1:0]};
            end
         end
      end
   endfunction

   wire [PORTS-1:0] roll_unmasked = (i_reass_roll   & {PORTS{serv_en_reg[0]}}) |
                                    (i_hdr_err_roll & {PORTS{serv_en_reg[1]}}) |
                                    (i_seq_err_roll & {PORTS{serv_en_reg[2]}}) |
                                    (i_lost_roll    & {PORTS{serv_en_reg[3]}});
   wire [PW:0]      roll_hit      = first_port(roll_unmasked);
   wire             evt_clear     = bus_wr & sel_evt & hi_lane &
                                    ~i_wb_dat[`URC_EVT_FLAG_BIT];

   // Limits are not reset; software programs a port's limit before that port
   // can go in sync with late checks on, otherwise an unknown limit is compared
   // per-port timeout store
   urc_timeout_mem #(
      .PORTS (PORTS),
      .AW    (PW),
      .DW    (TW)
   ) u_timeout_mem (
      .i_clock   (i_clock),
      .i_wr_en   (bus_wr & sel_tmo & lo_lane & hi_lane),
      .i_wr_addr (tmo_port),
      .i_wr_data (i_wb_dat[TW-1:0]),
      .i_rd_addr (bus_req ? tmo_port : scan_port_reg),
      .o_rd_data (tmo_rdata)
   );

   // Late-cell scan: one port per cycle compares its count with its limit.
   // The memory read port is shared with the bus, so any bus access, read or write, stalls the scan.
   reg [PW-1:0] scan_prev_reg;
   reg          scan_valid_reg;
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         scan_port_reg  <= {PW{1'b0}};
         scan_prev_reg  <= {PW{1'b0}};
         scan_valid_reg <= 1'b0;
      end else begin
         scan_valid_reg <= ~bus_req;
         scan_prev_reg  <= scan_port_reg;
         if (!bus_req) begin
            scan_port_reg <= scan_port_reg + 1'b1;
         end
      end
   end

   // Lowest-numbered port with a queued late-cell insertion
   wire [PW:0] late_pick = first_port(late_pend);

   // late timeout counters, one per port
   // Counters saturate, so a long-silent port cannot wrap and miss its limit
   genvar g;
   generate
      for (g = 0; g < PORTS; g = g + 1) begin : g_late
         reg [TW-1:0] cnt_reg;
         reg          pend_reg;
         wire         hit = scan_valid_reg && (scan_prev_reg == g) &&
                            (tmo_rdata != {TW{1'b0}}) && (cnt_reg >= tmo_rdata);
         assign late_pend[g] = pend_reg;
         always @(posedge i_clock or negedge i_resetn) begin
            if (!i_resetn) begin
               cnt_reg  <= {TW{1'b0}};
               pend_reg <= 1'b0;
            end else begin
               if (i_cell_arrived[g] || !i_port_in_sync[g] || hit) begin
                  cnt_reg <= {TW{1'b0}};
               end else if (cnt_reg != {TW{1'b1}}) begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
               // New timeout wins over the serving clear
               if (hit && i_port_in_sync[g] && fill_ctrl_reg[`URC_LATE_CHECK_BIT]) begin
                  pend_reg <= 1'b1;
               end else if (state_reg == ST_IDLE && !i_loss_valid &&
                            late_pick[PW] && late_pick[PW-1:0] == g) begin
                  pend_reg <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // A loss report waits in the engine while a cell is being written
   // lost-count mode, capped at seven
   wire [2:0] loss_cap   = fill_ctrl_reg[`URC_INSERT_LOST_BIT] ?
                           `URC_LOST_CAP_ON : `URC_LOST_CAP_OFF;
   wire [2:0] loss_cells = (i_loss_count > loss_cap) ? loss_cap : i_loss_count;
   assign o_loss_ready   = (state_reg == ST_IDLE);

   // dummy cell writer, 47 fill octets per cell
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg      <= ST_IDLE;
         octet_cnt_reg  <= 6'h00;
         cells_left_reg <= 3'h0;
         cur_port_reg   <= {PW{1'b0}};
         o_buf_wr       <= 1'b0;
         o_buf_port     <= {PW{1'b0}};
         o_buf_data     <= 8'h00;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               o_buf_wr <= 1'b0;
               if (i_loss_valid && loss_cells != 3'h0) begin
                  cur_port_reg   <= i_loss_port;
                  cells_left_reg <= loss_cells;
                  octet_cnt_reg  <= `URC_CELL_OCTETS;
                  state_reg      <= ST_WRITE;
               end else if (!i_loss_valid && late_pick[PW]) begin
                  cur_port_reg   <= late_pick[PW-1:0];
                  cells_left_reg <= 3'h1;
                  octet_cnt_reg  <= `URC_CELL_OCTETS;
                  state_reg      <= ST_WRITE;
               end
            end
            // Octets go out back to back; a stall holds data and port as they are
            ST_WRITE: begin
               if (o_buf_wr && !i_buf_ready) begin
                  o_buf_wr <= 1'b1; // Hold until the buffer takes it
               end else if (octet_cnt_reg != 6'h00) begin
                  o_buf_wr      <= 1'b1;
                  o_buf_port    <= cur_port_reg;
                  o_buf_data    <= fill_ctrl_reg[`URC_FILL_OCTET_HI:0];
                  octet_cnt_reg <= octet_cnt_reg - 1'b1;
               end else begin
                  o_buf_wr  <= 1'b0;
                  state_reg <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               if (cells_left_reg > 3'h1) begin
                  cells_left_reg <= cells_left_reg - 1'b1;
                  octet_cnt_reg  <= `URC_CELL_OCTETS;
                  state_reg      <= ST_WRITE;
               end else begin
                  cells_left_reg <= 3'h0;
                  state_reg      <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   wire cell_done = (state_reg == ST_NEXT) && (cells_left_reg <= 3'h1);

   // Control registers and summary event
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         fill_ctrl_reg <= FILL_RST[`URC_FILL_USED_W-1:0];
         serv_en_reg   <= SERV_RST[`URC_SERV_USED_W-1:0];
         evt_flag_reg  <= 1'b0;
         evt_port_reg  <= `URC_PORT_ILLEGAL;
         irq_mask_reg  <= {`URC_IRQ_W{1'b0}};
      end else begin
         if (bus_wr && sel_fill && lo_lane) begin
            fill_ctrl_reg[7:0] <= i_wb_dat[7:0];
         end
         if (bus_wr && sel_fill && hi_lane) begin
            fill_ctrl_reg[`URC_FILL_USED_W-1:8] <= i_wb_dat[`URC_FILL_USED_W-1:8];
         end
         if (bus_wr && sel_serv && lo_lane) begin
            serv_en_reg <= i_wb_dat[`URC_SERV_USED_W-1:0];
         end
         if (bus_wr && sel_imask && lo_lane) begin
            irq_mask_reg <= i_wb_dat[`URC_IRQ_W-1:0];
         end
         // Flag and port move together, so a read never sees them split
         // latest unmasked port; a new event wins over a clear
         // masked rollovers leave the flag alone
         if (roll_hit[PW]) begin
            evt_flag_reg <= 1'b1;
            evt_port_reg <= {{(5-PW){1'b0}}, roll_hit[PW-1:0]};
         // zero write clears flag and port
         end else if (evt_clear) begin
            evt_flag_reg <= 1'b0;
            evt_port_reg <= `URC_PORT_ILLEGAL;
         end
      end
   end

   // Sticky interrupt status, cleared by a read; a same-cycle event wins
   wire [`URC_IRQ_W-1:0] irq_events = {cell_done, roll_hit[PW]};
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_stat_reg <= {`URC_IRQ_W{1'b0}};
      end else if (bus_rd && sel_istat) begin
         irq_stat_reg <= irq_events;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_events;
      end
   end
   assign o_irq = |(irq_stat_reg & irq_mask_reg);

   // Read mux; memory reads need a second cycle for the registered data
   // Writes to the timeout store answer at once; only its reads wait
   reg tmo_wait_reg;
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_wb_ack     <= 1'b0;
         o_wb_dat     <= 32'h0000_0000;
         tmo_wait_reg <= 1'b0;
      end else begin
         o_wb_ack <= 1'b0;
         if (bus_rd && sel_tmo && !tmo_wait_reg) begin
            tmo_wait_reg <= 1'b1;
         end else if (bus_req) begin
            tmo_wait_reg <= 1'b0;
            o_wb_ack     <= 1'b1;
            // reserved bits and unmapped reads give zero
            o_wb_dat     <= 32'h0000_0000;
            if (!i_wb_we) begin
               if (sel_fill) begin
                  o_wb_dat[`URC_FILL_USED_W-1:0] <= fill_ctrl_reg;
               end else if (sel_serv) begin
                  o_wb_dat[`URC_SERV_USED_W-1:0] <= serv_en_reg;
               end else if (sel_evt) begin
                  o_wb_dat[`URC_EVT_FLAG_BIT] <= evt_flag_reg;
                  o_wb_dat[4:0]               <= evt_port_reg;
               end else if (sel_istat) begin
                  o_wb_dat[`URC_IRQ_W-1:0] <= irq_stat_reg;
               end else if (sel_imask) begin
                  o_wb_dat[`URC_IRQ_W-1:0] <= irq_mask_reg;
               end else if (sel_tmo) begin
                  o_wb_dat[TW-1:0] <= tmo_rdata;
               end
            end
         end
      end
   end

endmodule // urc_reassembly_ctrl

//--- verif/urc_reassembly_ctrl_props.sv
// Purpose: Port-level assertions for the reassembly control bank
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Octet run length is counted here because no port reports it
`timescale 1ns/100ps

module urc_reassembly_ctrl_props #(
   parameter PW = 3
) (
   // Clock and reset
   input wire logic          i_clock,
   input wire logic          i_resetn,
   // Register bus
   input wire logic          i_wb_cyc,
   input wire logic          i_wb_stb,
   input wire logic          i_wb_we,
   input wire logic [17:0]   i_wb_adr,
   input wire logic [31:0]   o_wb_dat,
   input wire logic          o_wb_ack,
   // Loss report and buffer writes
   input wire logic          i_loss_valid,
   input wire logic [2:0]    i_loss_count,
   input wire logic          o_loss_ready,
   input wire logic          o_buf_wr,
   input wire logic [PW-1:0] o_buf_port,
   input wire logic [7:0]    o_buf_data,
   input wire logic          i_buf_ready
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   // Accepted octets of the current cell; cleared in the gap between cells
   logic [5:0] run_cnt;
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn)
         run_cnt <= 6'h00;
      else if (!o_buf_wr)
         run_cnt <= 6'h00;
      else if (i_buf_ready)
         run_cnt <= run_cnt + 6'h01;
   end

   // Steps of a bus access and of a loss report
   sequence bus_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence rd_done;
      o_wb_ack && !$past(i_wb_we);
   endsequence
   sequence loss_take;
      i_loss_valid && o_loss_ready && (i_loss_count != 3'h0);
   endsequence

   ack_bound_a: assert property (bus_req |-> ##[1:2] o_wb_ack)
      else $error("bus request not answered in time");
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");
   ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_stb))
      else $error("ack without a request");
   hi_zero_a: assert property (rd_done |-> o_wb_dat[31:16] == 16'h0000)
      else $error("upper read half not zero");
   fill_rsvd_a: assert property (rd_done and $past(i_wb_adr) == 18'h0_8000
      |-> o_wb_dat[15:10] == 6'h00) else $error("fill control reserved bits set");
   serv_rsvd_a: assert property (rd_done and $past(i_wb_adr) == 18'h0_8008
      |-> o_wb_dat[15:4] == 12'h000) else $error("service enable reserved bits set");
   loss_start_a: assert property (loss_take |-> ##[1:2] o_buf_wr)
      else $error("loss report did not start a cell");
   busy_ready_a: assert property (o_buf_wr |-> !o_loss_ready)
      else $error("loss report accepted while writing");
   buf_hold_a: assert property (o_buf_wr && !i_buf_ready |=>
      o_buf_wr && $stable(o_buf_data) && $stable(o_buf_port)) else $error("write dropped");
   cell_len_a: assert property ($fell(o_buf_wr) |-> run_cnt == 6'h2F)
      else $error("cell length not 47 octets");
endmodule // urc_reassembly_ctrl_props

bind urc_reassembly_ctrl urc_reassembly_ctrl_props #(.PW(PW)) i_props (
   .i_clock(i_clock), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
   .i_loss_valid(i_loss_valid), .i_loss_count(i_loss_count), .o_loss_ready(o_loss_ready),
   .o_buf_wr(o_buf_wr), .o_buf_port(o_buf_port), .o_buf_data(o_buf_data),
   .i_buf_ready(i_buf_ready));

//--- verif/tb_urc_reassembly_ctrl.sv
// Purpose: Self-checking bench for the reassembly control bank
// Assumes: Register index is the byte address over four
// Notes:   Buffer ready stalls one cycle in four to exercise write hold
`timescale 1ns/100ps
`include "urc_consts.vh"

module tb_urc_reassembly_ctrl;
   // Stimulus and observation
   logic            i_clock, i_resetn, i_wb_cyc, i_wb_stb, i_wb_we;
   logic [17:0]     i_wb_adr;
   logic [31:0]     i_wb_dat, rd;
   logic [3:0][7:0] roll;
   logic            i_loss_valid, i_buf_ready;
   logic [2:0]      i_loss_port, i_loss_count, exp_port;
   logic [7:0]      i_port_in_sync, exp_octet;
   wire  [31:0]     o_wb_dat;
   wire             o_wb_ack, o_loss_ready, o_buf_wr, o_irq;
   wire  [2:0]      o_buf_port;
   wire  [7:0]      o_buf_data;
   int              err_total = 0, num_checks = 0, wr_cnt = 0, bad = 0, cyc_cnt = 0;

   urc_reassembly_ctrl i_urc_reassembly_ctrl (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
      .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(4'hF), .i_wb_dat(i_wb_dat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_reass_roll(roll[0]),
      .i_hdr_err_roll(roll[1]), .i_seq_err_roll(roll[2]), .i_lost_roll(roll[3]),
      .i_loss_valid(i_loss_valid), .i_loss_port(i_loss_port),
      .i_loss_count(i_loss_count), .o_loss_ready(o_loss_ready),
      .i_port_in_sync(i_port_in_sync), .i_cell_arrived(8'h00), .o_buf_wr(o_buf_wr),
      .o_buf_port(o_buf_port), .o_buf_data(o_buf_data), .i_buf_ready(i_buf_ready),
      .o_irq(o_irq));

   // Free-running clock
   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end

   // Octet monitor, stall pattern and hang guard
   always @(posedge i_clock) begin
      cyc_cnt++;
      i_buf_ready <= (cyc_cnt[1:0] != 2'h3);
      if (o_buf_wr === 1'b1 && i_buf_ready) begin
         wr_cnt++;
         if (o_buf_data !== exp_octet || o_buf_port !== exp_port)
            bad++;
      end
      if (cyc_cnt == 30000) begin
         err_total++;
         stop_test;
      end
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic cycle, held until ack is sampled high
   task xfer(input logic we, input logic [15:0] idx, input logic [15:0] wd);
      int n;
      n = 0;
      @(posedge i_clock);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we  <= we;
      i_wb_adr <= {idx, 2'h0};
      i_wb_dat <= {16'h0000, wd};
      do begin
         @(posedge i_clock);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 16);
      rd = o_wb_dat;
      if (n == 16)
         check(32'h0000_0000, 32'h0000_0001);
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
   endtask

   task wr(input logic [15:0] idx, input logic [15:0] d);
      xfer(1'b1, idx, d);
   endtask

   task rdc(input logic [15:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 16'h0000);
      check(rd, exp);
   endtask

   task pulse(input logic [3:0][7:0] v);
      @(posedge i_clock);
      roll <= v;
      @(posedge i_clock);
      roll <= '0;
   endtask

   // Waits until the cell writer is back in idle
   task wait_idle;
      int n;
      n = 0;
      repeat (3) @(posedge i_clock);
      while (!(o_loss_ready === 1'b1 && o_buf_wr === 1'b0) && n < 3000) begin
         @(posedge i_clock);
         n++;
      end
   endtask

   task t_regs;
      rdc(`URC_IDX_FILL_CTRL, 32'h0000_00FF);
      rdc(`URC_IDX_SERVICE_EN, 32'h0000_0000);
      rdc(`URC_IDX_EVENT_STATUS, 32'h0000_001F);
      wr(`URC_IDX_FILL_CTRL, 16'hFFFF);
      rdc(`URC_IDX_FILL_CTRL, 32'h0000_03FF);
      wr(`URC_IDX_SERVICE_EN, 16'hFFFF);
      rdc(`URC_IDX_SERVICE_EN, 32'h0000_000F);
      wr(16'h2001, 16'hFFFF);
      rdc(16'h2001, 32'h0000_0000);
      $display("test registers done");
   endtask

   task t_events;
      logic [3:0][7:0] v;
      wr(`URC_IDX_IRQ_MASK, 16'h0001);
      for (int k = 0; k < 4; k++) begin
         wr(`URC_IDX_SERVICE_EN, 16'h0001 << k);
         v = '0;
         for (int j = 0; j < 4; j++)
            if (j != k)
               v[j] = 8'h02;
         pulse(v);
         rdc(`URC_IDX_EVENT_STATUS, 32'h0000_001F);
         v = '0;
         v[k] = 8'h80 | (8'h01 << (k + 2));
         pulse(v);
         @(negedge i_clock);
         check(o_irq, 1'b1);
         rdc(`URC_IDX_EVENT_STATUS, 32'h8000 | (k + 2));
         wr(`URC_IDX_EVENT_STATUS, 16'h0000);
         rdc(`URC_IDX_EVENT_STATUS, 32'h0000_001F);
         rdc(`URC_IDX_IRQ_STATUS, 32'h0000_0001);
         @(negedge i_clock);
         check(o_irq, 1'b0);
      end
      // Masked interrupt still records the event
      wr(`URC_IDX_IRQ_MASK, 16'h0000);
      pulse(v);
      @(negedge i_clock);
      check(o_irq, 1'b0);
      rdc(`URC_IDX_IRQ_STATUS, 32'h0000_0001);
      wr(`URC_IDX_EVENT_STATUS, 16'h0000);
      $display("test events done");
   endtask

   task t_loss;
      static logic [2:0] cnt [5]   = '{3'h1, 3'h5, 3'h7, 3'h3, 3'h0};
      static logic       lost [5]  = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
      static int         cells [5] = '{1, 2, 7, 3, 0};
      for (int i = 0; i < 5; i++) begin
         exp_octet = 8'hA5 ^ i[7:0];
         exp_port  = i[2:0];
         wr(`URC_IDX_FILL_CTRL, {7'h00, lost[i], exp_octet});
         wr_cnt = 0;
         bad    = 0;
         @(posedge i_clock);
         i_loss_valid <= 1'b1;
         i_loss_port  <= exp_port;
         i_loss_count <= cnt[i];
         do @(posedge i_clock); while (o_loss_ready !== 1'b1);
         i_loss_valid <= 1'b0;
         wait_idle;
         check(wr_cnt, cells[i] * 47);
         check(bad, 0);
         rdc(`URC_IDX_IRQ_STATUS, {30'h0000_0000, cells[i] != 0, 1'b0});
      end
      $display("test loss done");
   endtask

   task t_late;
      int n;
      wr(`URC_IDX_TIMEOUT_BASE + 16'h0004, 16'h001E);
      wr(`URC_IDX_TIMEOUT_BASE + 16'h0006, 16'h0000);
      rdc(`URC_IDX_TIMEOUT_BASE + 16'h0004, 32'h0000_001E);
      wr(`URC_IDX_FILL_CTRL, 16'h00C3);
      exp_octet = 8'hC3;
      exp_port  = 3'h2;
      wr_cnt    = 0;
      bad       = 0;
      i_port_in_sync <= 8'h0C;
      repeat (100) @(posedge i_clock);
      check(wr_cnt, 0);
      i_port_in_sync <= 8'h00;
      wr(`URC_IDX_FILL_CTRL, 16'h02C3);
      i_port_in_sync <= 8'h0C;
      n = 0;
      while (o_buf_wr !== 1'b1 && n < 600) begin
         @(posedge i_clock);
         n++;
      end
      check(n >= 30 && n <= 50, 1'b1);
      n = 0;
      while (wr_cnt < 47 && n < 600) begin
         @(posedge i_clock);
         n++;
      end
      i_port_in_sync <= 8'h00;
      wait_idle;
      check(wr_cnt > 0 && wr_cnt % 47 == 0, 1'b1);
      check(bad, 0);
      $display("test late done");
   endtask

   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Reset for 16 cycles, then the scenarios in turn
   initial begin
      {i_resetn, i_wb_cyc, i_wb_stb, i_wb_we, i_loss_valid} = 5'h00;
      {i_wb_adr, i_wb_dat, roll, i_loss_port, i_loss_count} = '0;
      i_port_in_sync = 8'h00;
      repeat (16) @(posedge i_clock);
      i_resetn <= 1'b1;
      t_regs;
      t_events;
      t_loss;
      t_late;
      stop_test;
   end
endmodule // tb_urc_reassembly_ctrl
